/* File: design/fsal_core.sv */
/*
  Fault status and alert logic of a port power switch.
  Assumes a serial bus engine presents reads and writes as one-cycle strobes on clk_sys_i,
  and that comparator outputs and the switch enable arrive asynchronously from pins.
*/
`timescale 1ns/1ns
`default_nettype none
module fsal_core
  import fsal_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  // Comparator levels from the analog front end, and the switch enable
  input  wire logic         supply_ov_i,
  input  wire logic         back_volt_i,
  input  wire logic         over_lim_i,
  input  wire logic         over_r2min_i,
  input  wire logic         power_switch_enable_i,
  // Charge events from on-chip logic
  input  wire fsal_charge_s charge_i,
  // Register access
  input  wire logic         reg_rd_i,
  input  wire logic         reg_wr_i,
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic [7:0]   reg_wdata_i,
  output logic [7:0]        reg_rdata_o,
  // Open-drain alert and state
  output logic              alert_out_n_o,
  output logic              alert_oe_o,
  output logic              error_state_o
);

  // Two-flop synchronisers; the logic reads only the second stage, a_read_clears also the first. They run through reset so that the
  // enable edge detector starts from the pin's real level and sees no false toggle afterwards.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       power_switch_enable_q;
  always_ff @(posedge clk_sys_i) begin
    sync1    <= {power_switch_enable_i, over_r2min_i, over_lim_i, back_volt_i, supply_ov_i};
    sync2    <= sync1;
    power_switch_enable_q <= sync2[4];
  end

  fsal_fault_s cond;
  logic        power_switch_enable;
  assign cond.supply_ov = sync2[0];
  assign cond.back_volt = sync2[1];
  assign cond.over_cur  = sync2[2] & sync2[3];
  assign power_switch_enable         = sync2[4];

  logic rd_fault;
  logic rd_charge;
  logic wr_ctrl;
  assign rd_fault  = reg_rd_i && (reg_addr_i == FSAL_FAULT_STATUS_ADDR);
  assign rd_charge = reg_rd_i && (reg_addr_i == FSAL_CHARGE_STATUS_ADDR);
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == FSAL_CONTROL_ADDR);

  // State registers.
  fsal_fault_s faults;
  fsal_fault_s next_faults;
  logic        err_summary;
  logic        next_err_summary;
  logic        reset_ind;
  logic        next_reset_ind;
  logic        alert;
  logic        next_alert;
  logic        alert_n;
  logic        next_alert_n;
  logic [7:0]  next_rdata;

  logic pwr_toggle;
  assign pwr_toggle = power_switch_enable ^ power_switch_enable_q;

  always_comb begin
    // A read clears a flag only when its fault is gone; an active fault keeps it set whatever the summary.
    next_faults.supply_ov = cond.supply_ov |
      (faults.supply_ov & ~(rd_fault & (~cond.supply_ov | ~err_summary)));
    next_faults.back_volt = cond.back_volt |
      (faults.back_volt & ~(rd_fault & (~cond.back_volt | ~err_summary)));
    next_faults.over_cur  = cond.over_cur |
      (faults.over_cur & ~(rd_fault & (~cond.over_cur | ~err_summary)));
    // Set wins over a write of zero or a disabled switch.
    next_err_summary = (|cond) |
      (err_summary & ~(wr_ctrl & ~reg_wdata_i[FSAL_ERR_SUMMARY_BIT]) & power_switch_enable);
    next_reset_ind = reset_ind & ~rd_fault & ~pwr_toggle;
    // Alert is driven by the flags alone.
    next_alert = |next_faults;
    next_alert_n = ~next_alert;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      faults      <= '0;
      err_summary <= 1'b0;
      reset_ind   <= 1'b1;
      alert       <= 1'b0;
      alert_n     <= 1'b1;
    end else begin
      faults      <= next_faults;
      err_summary <= next_err_summary;
      reset_ind   <= next_reset_ind;
      alert       <= next_alert;
      alert_n     <= next_alert_n;
    end
  end

  // Charge event register: sticky bits clear on read, bits 3 and 4 follow live levels, bits 5 and 6 read zero.
  logic [FSAL_STICKY_COUNT-1:0] sticky_set;
  logic [FSAL_STICKY_COUNT-1:0] sticky_q;
  assign sticky_set = {charge_i.power_budget, charge_i.low_charge_current_flag, charge_i.removal, charge_i.attach};

  genvar g;
  generate
    for (g = 0; g < FSAL_STICKY_COUNT; g++) begin : g_sticky
      fsal_flag u_flag (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .rst_val_i (1'b0),
        .set_i     (sticky_set[g]),
        .clr_i     (rd_charge),
        .flag_o    (sticky_q[g])
      );
    end
  endgenerate

  logic [7:0] charge_view;
  always_comb begin
    charge_view                   = FSAL_CHARGE_RESET;
    charge_view[FSAL_ATTACH_BIT]  = sticky_q[0];
    charge_view[FSAL_REMOVAL_BIT] = sticky_q[1];
    charge_view[FSAL_LOW_CHARGE_CURRENT_FLAG_BIT] = sticky_q[2];
    charge_view[FSAL_THERMAL_REGULATION_FLAG_BIT]    = charge_i.thermal_reg;
    charge_view[FSAL_CONSTANT_CURRENT_FLAG_BIT] = charge_i.constant_current;
    charge_view[FSAL_BUDGET_BIT]  = sticky_q[3];
  end

  // Read data are captured on the read strobe and held until the next read.
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      next_rdata = 8'h00;
      unique case (reg_addr_i)
        FSAL_FAULT_STATUS_ADDR: begin
          next_rdata[FSAL_SUPPLY_OV_BIT]   = faults.supply_ov;
          next_rdata[FSAL_BACK_VOLT_BIT]   = faults.back_volt;
          next_rdata[FSAL_OVERCURRENT_BIT] = faults.over_cur;
          next_rdata[FSAL_RESET_IND_BIT]   = reset_ind;
        end
        FSAL_CHARGE_STATUS_ADDR: begin
          next_rdata = charge_view;
        end
        FSAL_CONTROL_ADDR: begin
          next_rdata[FSAL_ERR_SUMMARY_BIT] = err_summary;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= FSAL_RDATA_RESET;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Open-drain: the value is low whenever alert_oe_o is high, so the pad only ever pulls low.
  assign alert_out_n_o = alert_n;
  assign alert_oe_o    = alert;
  assign error_state_o = err_summary;

  sequence s_fault_seen;
    |cond;
  endsequence

  sequence s_alert_up;
    alert_oe_o && error_state_o;
  endsequence

  a_ov_sets_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cond.supply_ov |=> faults.supply_ov && error_state_o)
    else $error("overvoltage did not set flag and error");

  a_back_sets_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cond.back_volt |=> faults.back_volt)
    else $error("back-voltage did not set flag");

  a_oc_needs_both: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!faults.over_cur && !(sync2[2] && sync2[3])) |=> !faults.over_cur)
    else $error("overcurrent set without both thresholds");

  a_fault_alerts: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_fault_seen |=> s_alert_up)
    else $error("fault did not raise alert and error");

  a_read_keeps: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_fault && faults.over_cur && cond.over_cur) |=> faults.over_cur)
    else $error("active fault cleared by read");

  a_read_clears: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_fault && !(|cond) && !(|sync1[2:0])) |=> ##1 !alert_oe_o)
    else $error("read did not clear gone faults");

  a_pwr_clears_err: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!power_switch_enable && !(|cond)) |=> !error_state_o)
    else $error("summary not cleared with switch disabled");

  a_alert_indep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_ctrl && !reg_wdata_i[FSAL_ERR_SUMMARY_BIT] && !(|cond)) |=>
      $stable(alert_oe_o))
    else $error("summary clear changed alert");

  a_reset_no_alert: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (reset_ind && !(|faults)) |-> !alert_oe_o)
    else $error("reset indication raised alert");

  a_charge_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $past(rd_charge) |-> (reg_rdata_o[6:5] == 2'b00))
    else $error("unimplemented bits read nonzero");

endmodule
`default_nettype wire

/* File: design/fsal_pkg.sv */
/*
  Constants and types shared by the fault status and alert logic.
  Assumes the serial bus engine outside decodes register reads and writes into single-cycle strobes.
*/
// What this block does
// - Supply overvoltage sets bit 2 and Error.
// - Back-voltage over 150 mV sets bit 1.
// - Overcurrent needs limit and region-two threshold exceeded.
// - Any fault flag asserts alert and Error.
// - Read clears flag only if fault gone; an active fault keeps it set.
// - Switch enable deasserted clears summary flag.
// - Alert follows flags, not the summary flag.
// - Reset bit set at power-up, no alert.
package fsal_pkg;

  localparam logic [7:0] FSAL_FAULT_STATUS_ADDR  = 8'h10;
  localparam logic [7:0] FSAL_CHARGE_STATUS_ADDR = 8'h11;
  localparam logic [7:0] FSAL_CONTROL_ADDR       = 8'h14;

  localparam int FSAL_OVERCURRENT_BIT = 0;
  localparam int FSAL_BACK_VOLT_BIT   = 1;
  localparam int FSAL_SUPPLY_OV_BIT   = 2;
  localparam int FSAL_RESET_IND_BIT   = 5;
  localparam int FSAL_ERR_SUMMARY_BIT = 7;

  localparam int FSAL_ATTACH_BIT   = 0;
  localparam int FSAL_REMOVAL_BIT  = 1;
  localparam int FSAL_LOW_CHARGE_CURRENT_FLAG_BIT  = 2;
  localparam int FSAL_THERMAL_REGULATION_FLAG_BIT     = 3;
  localparam int FSAL_CONSTANT_CURRENT_FLAG_BIT  = 4;
  localparam int FSAL_BUDGET_BIT   = 7;
  localparam int FSAL_STICKY_COUNT = 4;

  localparam logic [7:0] FSAL_CHARGE_RESET = 8'h00;
  localparam logic [7:0] FSAL_RDATA_RESET  = 8'h00;

  typedef struct packed {
    logic supply_ov;
    logic back_volt;
    logic over_cur;
  } fsal_fault_s;

  typedef struct packed {
    logic power_budget;
    logic constant_current;
    logic thermal_reg;
    logic low_charge_current_flag;
    logic removal;
    logic attach;
  } fsal_charge_s;

endpackage

/* File: design/fsal_flag.sv */
/*
  One sticky status flag with set priority over clear.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module fsal_flag (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // Control
  input  wire logic rst_val_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  // State
  output logic      flag_o
);

  logic next_flag;

  // An event in the same cycle as its clear must not be lost, so set wins.
  always_comb begin
    next_flag = set_i | (flag_o & ~clr_i);
  end

  // The reset is synchronous, so rst_val_i lets a flag come up set straight out of reset.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flag_o <= rst_val_i;
    end else begin
      flag_o <= next_flag;
    end
  end

  a_flag_set_wins: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    set_i |=> flag_o)
    else $error("sticky flag lost a set event");

  a_flag_holds: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (flag_o && !clr_i) |=> flag_o)
    else $error("sticky flag dropped without clear");

endmodule
`default_nettype wire

/* File: tb/fsal_host_model.sv */
/*
  Behavioural management-bus host that issues register reads and writes to the fault logic.
  Assumes the block takes one-cycle strobes and answers a read on the next rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module fsal_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Register port
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // Idle address lines show the inverse of the last address; a read leaves the write data lines as they were.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys_i);
    reg_rd_o   = 1'b1;
    reg_addr_o = addr;
    @(negedge clk_sys_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    data       = reg_rdata_i;
  endtask

  // Clearing the summary flag takes a write of zero or a disabled switch.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    @(negedge clk_sys_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_fault_status_alert_logic.sv */
/*
  Self-checking bench for the fault status and alert logic.
  Assumes flags land three edges after a comparator rises, so four cycles are waited.
*/
`timescale 1ns/1ns
`default_nettype none
module test_fault_status_alert_logic;
  import fsal_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic sov = 1'b0, bv = 1'b0, olim = 1'b0, or2 = 1'b0, en = 1'b1;
  fsal_charge_s chg = '0;
  logic rd, wr, oe, err, aon;
  logic [7:0] addr, wdata, rdata, d;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  fsal_host_model host (.clk_sys_i(clk_sys_i), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  fsal_core dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .supply_ov_i(sov),
    .back_volt_i(bv), .over_lim_i(olim), .over_r2min_i(or2),
    .power_switch_enable_i(en), .charge_i(chg), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .alert_out_n_o(aon), .alert_oe_o(oe), .error_state_o(err));

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Status bit 7 reads zero; the summary sits at control bit 7 and is judged through the pin instead.
  task automatic rchk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    host.rd(a, d);
    chk(d & mask, exp);
  endtask

  task automatic pins(input logic a, input logic e);
    chk({5'h00, aon, oe, err}, {5'h00, ~a, a, e});
  endtask

  task automatic settle();
    repeat (4) @(negedge clk_sys_i);
  endtask

  initial begin
    repeat (5) @(negedge clk_sys_i);
    reset_i = 1'b0;
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h20);
    pins(1'b0, 1'b0);
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h00);
    $display("Test reset indication done");
    sov = 1'b1;
    settle();
    pins(1'b1, 1'b1);
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h04);
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h04);
    sov = 1'b0;
    settle();
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h04);
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h00);
    @(negedge clk_sys_i);
    pins(1'b0, 1'b1);
    host.wr(FSAL_CONTROL_ADDR, 8'h00);
    @(negedge clk_sys_i);
    pins(1'b0, 1'b0);
    $display("Test supply overvoltage done");
    bv = 1'b1;
    settle();
    pins(1'b1, 1'b1);
    bv = 1'b0;
    settle();
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h02);
    en = 1'b0;
    settle();
    pins(1'b0, 1'b0);
    en = 1'b1;
    settle();
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h00);
    $display("Test back voltage done");
    olim = 1'b1;
    settle();
    pins(1'b0, 1'b0);
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h00);
    or2 = 1'b1;
    settle();
    pins(1'b1, 1'b1);
    olim = 1'b0;
    or2 = 1'b0;
    settle();
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h01);
    host.wr(FSAL_CONTROL_ADDR, 8'h00);
    $display("Test overcurrent done");
    host.wr(FSAL_CHARGE_STATUS_ADDR, 8'hFF);
    chg = '1;
    settle();
    rchk(FSAL_CHARGE_STATUS_ADDR, 8'h60, 8'h00);
    rchk(FSAL_CHARGE_STATUS_ADDR, 8'h18, 8'h18);
    rchk(FSAL_CHARGE_STATUS_ADDR, 8'hFF, 8'h9F);
    chg = '0;
    rchk(FSAL_CHARGE_STATUS_ADDR, 8'hFF, 8'h87);
    rchk(FSAL_CHARGE_STATUS_ADDR, 8'hFF, 8'h00);
    rchk(8'hFE, 8'hFF, 8'h00);
    pins(1'b0, 1'b0);
    $display("Test charge register done");
    reset_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    reset_i = 1'b0;
    pins(1'b0, 1'b0);
    en = 1'b0;
    settle();
    rchk(FSAL_FAULT_STATUS_ADDR, 8'h7F, 8'h00);
    en = 1'b1;
    settle();
    $display("Test enable toggle clears reset bit done");
    end_sim();
  end
endmodule
`default_nettype wire
